// ---- cpu_frag_pkg.sv ----
// shared constants and types for the test, transfer, wait and addressing fragment
package cpu_frag_pkg;

    // opcodes, single byte
    localparam logic [7:0] OPC_TST_DIR   = 8'h3d;
    localparam logic [7:0] OPC_TSTA      = 8'h4d;
    localparam logic [7:0] OPC_TSTX      = 8'h5d;
    localparam logic [7:0] OPC_TST_IX1   = 8'h6d;
    localparam logic [7:0] OPC_TST_IX    = 8'h7d;
    localparam logic [7:0] OPC_MOV_DD    = 8'h4e;
    localparam logic [7:0] OPC_MOV_DIXP  = 8'h5e;
    localparam logic [7:0] OPC_MOV_IMD   = 8'h6e;
    localparam logic [7:0] OPC_MOV_IXPD  = 8'h7e;
    localparam logic [7:0] OPC_CBEQ_IX1P = 8'h61;
    localparam logic [7:0] OPC_LDA_EXT   = 8'hc6;
    localparam logic [7:0] OPC_LDA_IX2   = 8'hd6;
    localparam logic [7:0] OPC_LDA_SP2   = 8'hd6;
    localparam logic [7:0] OPC_TPA       = 8'h85;
    localparam logic [7:0] OPC_WAIT      = 8'h8f;
    localparam logic [7:0] OPC_TXS       = 8'h94;
    localparam logic [7:0] OPC_TSX       = 8'h95;
    localparam logic [7:0] OPC_TXA       = 8'h9f;
    localparam logic [7:0] OPC_SP_PREFIX = 8'h9e;
    localparam logic [7:0] OPC_TST_SP1   = 8'h6d;

    // condition flag bit positions
    localparam int FLG_V = 7;
    localparam int FLG_H = 4;
    localparam int FLG_I = 3;
    localparam int FLG_N = 2;
    localparam int FLG_Z = 1;
    localparam int FLG_C = 0;

    // reset values
    localparam logic [7:0]  RST_FLAGS = 8'h68;
    localparam logic [15:0] RST_SP    = 16'h00ff;
    localparam logic [15:0] RST_PC    = 16'h0000;

    typedef enum logic [3:0] {
        ST_FETCH = 4'b0000,
        ST_PRE   = 4'b0001,
        ST_OP1   = 4'b0010,
        ST_OP2   = 4'b0011,
        ST_READ  = 4'b0100,
        ST_WRITE = 4'b0101,
        ST_XFER  = 4'b0110,
        ST_WAIT  = 4'b0111
    } state_type;

    typedef enum logic [3:0] {
        M_INH  = 4'b0000, M_DIR  = 4'b0001, M_IX   = 4'b0010, M_IX1  = 4'b0011,
        M_IX2  = 4'b0100, M_SP1  = 4'b0101, M_SP2  = 4'b0110, M_EXT  = 4'b0111,
        M_IX1P = 4'b1000, M_DD   = 4'b1001, M_DIXP = 4'b1010, M_IXPD = 4'b1011,
        M_IMD  = 4'b1100
    } mode_type;

    typedef enum logic [3:0] {
        K_NOP  = 4'b0000, K_TST  = 4'b0001, K_TSTA = 4'b0010, K_TSTX = 4'b0011,
        K_LDA  = 4'b0100, K_CBEQ = 4'b0101, K_MOV  = 4'b0110, K_TPA  = 4'b0111,
        K_TXA  = 4'b1000, K_TSX  = 4'b1001, K_TXS  = 4'b1010, K_WAIT = 4'b1011
    } kind_type;

    typedef struct packed {
        mode_type mode;
        kind_type kind;
    } decode_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } mem_req_type;

    typedef struct packed {
        logic [7:0]  acc;
        logic [15:0] hx;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0]  flags;
    } cpu_regs_type;

endpackage

// ---- cpu_test_wait_addressing_decode.sv ----
// test, transfer and wait instructions with the indexed, stack, extended and move address modes
`timescale 1ns/1ns
module cpu_test_wait_addressing_decode (
    // clock and reset
    input  logic                       clock_i,
    input  logic                       rst_n_i,
    // memory and peripheral bus
    input  logic [7:0]                 mem_rdata_i,
    output cpu_frag_pkg::mem_req_type  mem_req_o,
    // interrupt logic
    input  logic                       irq_i,
    output logic                       waiting_o,
    // visible programmer state
    output cpu_frag_pkg::cpu_regs_type regs_o
);

    cpu_frag_pkg::state_type    state_r, state_nxt;
    cpu_frag_pkg::decode_type   dec_r, dec_nxt, dec_now;
    cpu_frag_pkg::mem_req_type  req_r, req_nxt;
    cpu_frag_pkg::cpu_regs_type cr_r, cr_nxt;
    logic [7:0]                 op1_r, op1_nxt;
    logic [7:0]                 op2_r, op2_nxt;
    logic [15:0]                dst_r, dst_nxt;
    logic                       wait_r, wait_nxt;

    // opcode classification, used for plain and prefixed fetches
    function automatic cpu_frag_pkg::decode_type decode(input logic pre, input logic [7:0] opc);
        cpu_frag_pkg::decode_type d;
        d = '{mode: cpu_frag_pkg::M_INH, kind: cpu_frag_pkg::K_NOP};
        if (pre) begin
            case (opc)
                cpu_frag_pkg::OPC_TST_SP1: d = '{cpu_frag_pkg::M_SP1, cpu_frag_pkg::K_TST};
                cpu_frag_pkg::OPC_LDA_SP2: d = '{cpu_frag_pkg::M_SP2, cpu_frag_pkg::K_LDA};
                default:                   d = '{cpu_frag_pkg::M_INH, cpu_frag_pkg::K_NOP};
            endcase
        end else begin
            case (opc)
                cpu_frag_pkg::OPC_TST_DIR:   d = '{cpu_frag_pkg::M_DIR,  cpu_frag_pkg::K_TST};
                cpu_frag_pkg::OPC_TSTA:      d = '{cpu_frag_pkg::M_INH,  cpu_frag_pkg::K_TSTA};
                cpu_frag_pkg::OPC_TSTX:      d = '{cpu_frag_pkg::M_INH,  cpu_frag_pkg::K_TSTX};
                cpu_frag_pkg::OPC_TST_IX1:   d = '{cpu_frag_pkg::M_IX1,  cpu_frag_pkg::K_TST};
                cpu_frag_pkg::OPC_TST_IX:    d = '{cpu_frag_pkg::M_IX,   cpu_frag_pkg::K_TST};
                cpu_frag_pkg::OPC_MOV_DD:    d = '{cpu_frag_pkg::M_DD,   cpu_frag_pkg::K_MOV};
                cpu_frag_pkg::OPC_MOV_DIXP:  d = '{cpu_frag_pkg::M_DIXP, cpu_frag_pkg::K_MOV};
                cpu_frag_pkg::OPC_MOV_IMD:   d = '{cpu_frag_pkg::M_IMD,  cpu_frag_pkg::K_MOV};
                cpu_frag_pkg::OPC_MOV_IXPD:  d = '{cpu_frag_pkg::M_IXPD, cpu_frag_pkg::K_MOV};
                cpu_frag_pkg::OPC_CBEQ_IX1P: d = '{cpu_frag_pkg::M_IX1P, cpu_frag_pkg::K_CBEQ};
                cpu_frag_pkg::OPC_LDA_EXT:   d = '{cpu_frag_pkg::M_EXT,  cpu_frag_pkg::K_LDA};
                cpu_frag_pkg::OPC_LDA_IX2:   d = '{cpu_frag_pkg::M_IX2,  cpu_frag_pkg::K_LDA};
                cpu_frag_pkg::OPC_TPA:       d = '{cpu_frag_pkg::M_INH,  cpu_frag_pkg::K_TPA};
                cpu_frag_pkg::OPC_TXA:       d = '{cpu_frag_pkg::M_INH,  cpu_frag_pkg::K_TXA};
                cpu_frag_pkg::OPC_TSX:       d = '{cpu_frag_pkg::M_INH,  cpu_frag_pkg::K_TSX};
                cpu_frag_pkg::OPC_TXS:       d = '{cpu_frag_pkg::M_INH,  cpu_frag_pkg::K_TXS};
                cpu_frag_pkg::OPC_WAIT:      d = '{cpu_frag_pkg::M_INH,  cpu_frag_pkg::K_WAIT};
                default:                     d = '{cpu_frag_pkg::M_INH,  cpu_frag_pkg::K_NOP};
            endcase
        end
        return d;
    endfunction

    // modes that carry two operand bytes
    function automatic logic two_ops(input cpu_frag_pkg::mode_type m);
        return m inside {cpu_frag_pkg::M_IX2, cpu_frag_pkg::M_SP2, cpu_frag_pkg::M_EXT,
                         cpu_frag_pkg::M_IX1P, cpu_frag_pkg::M_DD, cpu_frag_pkg::M_IMD};
    endfunction

    // source address once all operand bytes are in; o1 is the first byte fetched
    function automatic logic [15:0] src_addr(input cpu_frag_pkg::mode_type m,
                                             input logic [7:0] o1, input logic [7:0] o2,
                                             input logic [15:0] hx, input logic [15:0] sp);
        case (m)
            cpu_frag_pkg::M_DIR,
            cpu_frag_pkg::M_DD,
            cpu_frag_pkg::M_DIXP: return {8'h00, o1};
            cpu_frag_pkg::M_IX1,
            cpu_frag_pkg::M_IX1P: return hx + {8'h00, o1};
            cpu_frag_pkg::M_SP1:  return sp + {8'h00, o1};
            cpu_frag_pkg::M_SP2:  return sp + {o1, o2};
            cpu_frag_pkg::M_IX2:  return hx + {o1, o2};
            cpu_frag_pkg::M_EXT:  return {o1, o2};
            default:              return hx;
        endcase
    endfunction

    // a test or load leaves carry, half carry and mask alone
    function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
        logic [7:0] r;
        r = f;
        r[cpu_frag_pkg::FLG_V] = 1'b0;
        r[cpu_frag_pkg::FLG_N] = v[7];
        r[cpu_frag_pkg::FLG_Z] = (v == 8'h00);
        return r;
    endfunction

    assign dec_now = decode(state_r == cpu_frag_pkg::ST_PRE, mem_rdata_i);

    // one step of the sequencer: memory is combinational, data is valid in the access cycle
    always_comb begin
        state_nxt = state_r;
        dec_nxt   = dec_r;
        req_nxt   = '{addr: cr_r.pc, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
        cr_nxt    = cr_r;
        op1_nxt   = op1_r;
        op2_nxt   = op2_r;
        dst_nxt   = dst_r;
        wait_nxt  = 1'b0;
        case (state_r)
            cpu_frag_pkg::ST_FETCH,
            cpu_frag_pkg::ST_PRE: begin
                cr_nxt.pc = cr_r.pc + 16'h0001;
                req_nxt.addr = cr_nxt.pc;
                dec_nxt = dec_now;
                state_nxt = cpu_frag_pkg::ST_FETCH;
                if (state_r == cpu_frag_pkg::ST_FETCH && mem_rdata_i == cpu_frag_pkg::OPC_SP_PREFIX) begin
                    state_nxt = cpu_frag_pkg::ST_PRE;
                end else begin
                    case (dec_now.kind)
                        cpu_frag_pkg::K_TSTA: cr_nxt.flags = nz_flags(cr_r.flags, cr_r.acc);
                        cpu_frag_pkg::K_TSTX: cr_nxt.flags = nz_flags(cr_r.flags, cr_r.hx[7:0]);
                        cpu_frag_pkg::K_TPA:  cr_nxt.acc = cr_r.flags;
                        cpu_frag_pkg::K_TXA:  cr_nxt.acc = cr_r.hx[7:0];
                        cpu_frag_pkg::K_TSX,
                        cpu_frag_pkg::K_TXS:  state_nxt = cpu_frag_pkg::ST_XFER;
                        cpu_frag_pkg::K_WAIT: begin
                            cr_nxt.flags[cpu_frag_pkg::FLG_I] = 1'b0;
                            state_nxt = cpu_frag_pkg::ST_WAIT;
                            req_nxt.rd = 1'b0;
                            wait_nxt = 1'b1;
                        end
                        cpu_frag_pkg::K_NOP: state_nxt = cpu_frag_pkg::ST_FETCH;
                        default: begin
                            if (dec_now.mode == cpu_frag_pkg::M_IX) begin
                                state_nxt = cpu_frag_pkg::ST_READ;
                                req_nxt.addr = cr_r.hx;
                            end else begin
                                state_nxt = cpu_frag_pkg::ST_OP1;
                            end
                        end
                    endcase
                end
            end
            cpu_frag_pkg::ST_OP1: begin
                op1_nxt = mem_rdata_i;
                cr_nxt.pc = cr_r.pc + 16'h0001;
                if (two_ops(dec_r.mode)) begin
                    state_nxt = cpu_frag_pkg::ST_OP2;
                    req_nxt.addr = cr_nxt.pc;
                end else begin
                    state_nxt = cpu_frag_pkg::ST_READ;
                    req_nxt.addr = src_addr(dec_r.mode, mem_rdata_i, 8'h00, cr_r.hx, cr_r.sp);
                    dst_nxt = (dec_r.mode == cpu_frag_pkg::M_DIXP) ? cr_r.hx
                                                                   : {8'h00, mem_rdata_i};
                    if (dec_r.mode == cpu_frag_pkg::M_IXPD) begin
                        req_nxt.addr = cr_r.hx;
                    end
                end
            end
            cpu_frag_pkg::ST_OP2: begin
                op2_nxt = mem_rdata_i;
                cr_nxt.pc = cr_r.pc + 16'h0001;
                dst_nxt = {8'h00, mem_rdata_i};
                if (dec_r.mode == cpu_frag_pkg::M_IMD) begin
                    // immediate goes straight to the bus, no register touched
                    state_nxt = cpu_frag_pkg::ST_WRITE;
                    req_nxt = '{addr: {8'h00, mem_rdata_i}, wdata: op1_r, rd: 1'b0, wr: 1'b1};
                end else begin
                    state_nxt = cpu_frag_pkg::ST_READ;
                    req_nxt.addr = src_addr(dec_r.mode, op1_r, mem_rdata_i, cr_r.hx, cr_r.sp);
                end
            end
            cpu_frag_pkg::ST_READ: begin
                state_nxt = cpu_frag_pkg::ST_FETCH;
                case (dec_r.kind)
                    cpu_frag_pkg::K_TST: cr_nxt.flags = nz_flags(cr_r.flags, mem_rdata_i);
                    cpu_frag_pkg::K_LDA: begin
                        cr_nxt.acc = mem_rdata_i;
                        cr_nxt.flags = nz_flags(cr_r.flags, mem_rdata_i);
                    end
                    cpu_frag_pkg::K_CBEQ: begin
                        cr_nxt.hx = cr_r.hx + 16'h0001;
                        if (cr_r.acc == mem_rdata_i) begin
                            cr_nxt.pc = cr_r.pc + {{8{op2_r[7]}}, op2_r};
                        end
                        req_nxt.addr = cr_nxt.pc;
                    end
                    cpu_frag_pkg::K_MOV: begin
                        // moves other than the immediate one report the byte in N and Z like a load
                        cr_nxt.flags = nz_flags(cr_r.flags, mem_rdata_i);
                        state_nxt = cpu_frag_pkg::ST_WRITE;
                        req_nxt = '{addr: dst_r, wdata: mem_rdata_i, rd: 1'b0, wr: 1'b1};
                        if (dec_r.mode == cpu_frag_pkg::M_IXPD) begin
                            cr_nxt.hx = cr_r.hx + 16'h0001;
                        end
                    end
                    default: state_nxt = cpu_frag_pkg::ST_FETCH;
                endcase
            end
            cpu_frag_pkg::ST_WRITE: begin
                state_nxt = cpu_frag_pkg::ST_FETCH;
                if (dec_r.mode == cpu_frag_pkg::M_DIXP) begin
                    cr_nxt.hx = cr_r.hx + 16'h0001;
                end
            end
            cpu_frag_pkg::ST_XFER: begin
                state_nxt = cpu_frag_pkg::ST_FETCH;
                if (dec_r.kind == cpu_frag_pkg::K_TSX) begin
                    cr_nxt.hx = cr_r.sp + 16'h0001;
                end else begin
                    cr_nxt.sp = cr_r.hx - 16'h0001;
                end
            end
            cpu_frag_pkg::ST_WAIT: begin
                // bus idles while stopped; only the interrupt logic restarts fetching
                if (irq_i) begin
                    state_nxt = cpu_frag_pkg::ST_FETCH;
                end else begin
                    req_nxt.rd = 1'b0;
                    wait_nxt = 1'b1;
                end
            end
            default: state_nxt = cpu_frag_pkg::ST_FETCH;
        endcase
    end

    // sequencer and bus request
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= cpu_frag_pkg::ST_FETCH;
            dec_r   <= '{mode: cpu_frag_pkg::M_INH, kind: cpu_frag_pkg::K_NOP};
            req_r   <= '{addr: cpu_frag_pkg::RST_PC, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
            wait_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dec_r   <= dec_nxt;
            req_r   <= req_nxt;
            wait_r  <= wait_nxt;
        end
    end

    // programmer state and operand latches
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cr_r  <= '{acc: 8'h00, hx: 16'h0000, sp: cpu_frag_pkg::RST_SP,
                       pc: cpu_frag_pkg::RST_PC, flags: cpu_frag_pkg::RST_FLAGS};
            op1_r <= 8'h00;
            op2_r <= 8'h00;
            dst_r <= 16'h0000;
        end else begin
            cr_r  <= cr_nxt;
            op1_r <= op1_nxt;
            op2_r <= op2_nxt;
            dst_r <= dst_nxt;
        end
    end

    assign mem_req_o = req_r;
    assign regs_o    = cr_r;
    assign waiting_o = wait_r;

    AST_TST_FLAGS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_READ && dec_r.kind == cpu_frag_pkg::K_TST |=>
        !cr_r.flags[7] && cr_r.flags[2] == $past(mem_rdata_i[7]) && cr_r.flags[4] == $past(cr_r.flags[4])
        && cr_r.flags[0] == $past(cr_r.flags[0]) && cr_r.flags[3] == $past(cr_r.flags[3]))
        else $error("test flags wrong");
    AST_TST_DIR_CYCLES: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_FETCH && mem_rdata_i == cpu_frag_pkg::OPC_TST_DIR |=>
        state_r == cpu_frag_pkg::ST_OP1 ##1 state_r == cpu_frag_pkg::ST_READ
        ##1 state_r == cpu_frag_pkg::ST_FETCH)
        else $error("direct test not three cycles");
    AST_WAIT_STOP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_FETCH && mem_rdata_i == cpu_frag_pkg::OPC_WAIT && !irq_i |=>
        !cr_r.flags[3] && waiting_o && !mem_req_o.rd ##1 waiting_o || $past(irq_i))
        else $error("wait did not stop");
    AST_SP_PREFIX: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_FETCH && mem_rdata_i == cpu_frag_pkg::OPC_SP_PREFIX |=>
        state_r == cpu_frag_pkg::ST_PRE)
        else $error("prefix not taken");
    AST_IX1P_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_READ && dec_r.mode == cpu_frag_pkg::M_IX1P |->
        mem_req_o.addr == $past(cr_r.hx, 3) + {8'h00, op1_r} ##1 cr_r.hx == $past(cr_r.hx) + 16'h0001)
        else $error("offset post increment wrong");
    AST_DIXP_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_WRITE && dec_r.mode == cpu_frag_pkg::M_DIXP |->
        mem_req_o.wr && mem_req_o.addr == cr_r.hx ##1 cr_r.hx == $past(cr_r.hx) + 16'h0001)
        else $error("direct to index move wrong");
    AST_IXPD_READ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_READ && dec_r.mode == cpu_frag_pkg::M_IXPD |->
        mem_req_o.addr == cr_r.hx ##1 mem_req_o.wr && mem_req_o.addr == {8'h00, op1_r}
        && cr_r.hx == $past(cr_r.hx) + 16'h0001)
        else $error("index to direct move wrong");
    AST_SP_ADDR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_READ && dec_r.mode == cpu_frag_pkg::M_SP1 |->
        mem_req_o.addr == cr_r.sp + {8'h00, op1_r})
        else $error("stack offset address wrong");
    AST_IX2_ADDR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_READ && dec_r.mode == cpu_frag_pkg::M_IX2 |->
        mem_req_o.addr == cr_r.hx + {op1_r, op2_r})
        else $error("16-bit index address wrong");
    AST_EXT_ADDR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_READ && dec_r.mode == cpu_frag_pkg::M_EXT |->
        mem_req_o.addr == {op1_r, op2_r})
        else $error("extended address wrong");
    AST_IMD_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_WRITE && dec_r.mode == cpu_frag_pkg::M_IMD |->
        mem_req_o.wdata == op1_r && mem_req_o.addr == {8'h00, op2_r} && $stable(cr_r.acc))
        else $error("immediate move wrong");
    AST_DD_COPY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_READ && dec_r.mode == cpu_frag_pkg::M_DD |=>
        mem_req_o.wr && mem_req_o.addr == {8'h00, op2_r} && mem_req_o.wdata == $past(mem_rdata_i))
        else $error("direct to direct move wrong");
    AST_TSX_XFER: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_XFER |=> $stable(cr_r.flags) &&
        (cr_r.hx == $past(cr_r.sp) + 16'h0001 || cr_r.sp == $past(cr_r.hx) - 16'h0001))
        else $error("stack index transfer wrong");
    AST_TPA_ONE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_r == cpu_frag_pkg::ST_FETCH && mem_rdata_i == cpu_frag_pkg::OPC_TPA |=>
        cr_r.acc == $past(cr_r.flags) && $stable(cr_r.flags) && state_r == cpu_frag_pkg::ST_FETCH)
        else $error("flag copy wrong");

endmodule

// ---- mem_model.sv ----
// memory and peripheral bus model: same-cycle read, write on the rising edge
`timescale 1ns/1ns
module mem_model (
    // clock
    input  wire logic                      clock_i,
    // bus from the core
    input  wire cpu_frag_pkg::mem_req_type req_i,
    output logic [7:0]                     rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h00;
    // an idle bus shows the inverse of the last byte so stale data never looks valid
    always @* begin
        rdata_o = req_i.rd ? mem[req_i.addr] : ~last_r;
    end
    always @(posedge clock_i) begin
        if (req_i.wr) begin
            mem[req_i.addr] <= req_i.wdata;
        end
        if (req_i.rd) begin
            last_r <= mem[req_i.addr];
        end
    end
endmodule

// ---- tb_cpu_test_wait_addressing_decode.sv ----
// self-checking bench for the test, transfer, wait and addressing fragment
`timescale 1ns/1ns
module tb_cpu_test_wait_addressing_decode;
    typedef struct packed {logic [15:0] a; logic [7:0] d;} wr_note_type;
    typedef struct packed {logic [15:0] pc; logic [7:0] acc;
        logic [15:0] hx; logic [15:0] sp; logic [7:0] fl;} st_note_type;
    logic                       clock_i = 1'b0;
    logic                       rst_n_i = 1'b0;
    logic                       irq_i   = 1'b0;
    logic [7:0]                 mem_rdata_i;
    cpu_frag_pkg::mem_req_type  mem_req_o;
    logic                       waiting_o;
    cpu_frag_pkg::cpu_regs_type regs_o;
    wr_note_type                wq[$];
    st_note_type                sq[$];
    logic [7:0]                 prog[$];
    logic [7:0]                 r [0:4];
    int                         bad_count = 0;
    int                         n_tests = 0;
    int                         k;

    always #50 clock_i = ~clock_i;

    cpu_test_wait_addressing_decode i_cpu_test_wait_addressing_decode (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o), .irq_i(irq_i),
        .waiting_o(waiting_o), .regs_o(regs_o));
    mem_model i_mem_model (.clock_i(clock_i), .req_i(mem_req_o), .rdata_o(mem_rdata_i));

    function automatic logic [7:0] nz(input logic [7:0] f, input logic [7:0] v);
        return {1'b0, f[6:3], v[7], v == 8'h00, f[0]};
    endfunction
    task automatic fail(input string m);
        bad_count++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic cmp_wr(input wr_note_type got, input wr_note_type exp);
        n_tests++;
        if (got !== exp) fail($sformatf("write %h, expected %h", got, exp));
    endtask
    task automatic cmp_st(input st_note_type got, input st_note_type exp);
        n_tests++;
        if (got !== exp) fail($sformatf("state %h, expected %h", got, exp));
    endtask
    task automatic cmp_bit(input logic got, input string m);
        n_tests++;
        if (got !== 1'b1) fail(m);
    endtask
    task automatic ns(input logic [15:0] pc, input logic [7:0] a, input logic [15:0] hx,
                      input logic [15:0] sp, input logic [7:0] f);
        sq.push_back({pc, a, hx, sp, f});
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // state is compared at the opcode fetch that follows the instruction under test
    always @(negedge clock_i) begin
        if (rst_n_i && mem_req_o.wr === 1'b1) begin
            if (wq.size() == 0) fail("unexpected write");
            else cmp_wr({mem_req_o.addr, mem_req_o.wdata}, wq.pop_front());
        end
        if (rst_n_i && mem_req_o.rd === 1'b1 && sq.size() != 0 && mem_req_o.addr === sq[0].pc)
            cmp_st({mem_req_o.addr, regs_o.acc, regs_o.hx, regs_o.sp, regs_o.flags},
                   sq.pop_front());
    end

    initial begin
        #400000;
        fail("timeout");
        give_verdict();
    end

    initial begin
        void'($urandom(32'hdcce));
        for (k = 0; k < 5; k++) r[k] = 8'($urandom());
        for (k = 0; k < 65536; k++) i_mem_model.mem[k] = 8'h00;
        prog = {8'h95, 8'h6e, r[0], 8'h40, 8'h4e, 8'h40, 8'h41, 8'h5e, 8'h41, 8'h7e, 8'h42,
                8'h61, 8'hff, 8'h00, 8'hc6, 8'h12, 8'h34, 8'hd6, 8'h01, 8'h00, 8'h9e, 8'hd6,
                8'h01, 8'h02, 8'h9e, 8'h6d, 8'h03, 8'h3d, 8'h43, 8'h85, 8'h94, 8'h9f, 8'h8f,
                8'h8f};
        foreach (prog[i]) i_mem_model.mem[i] = prog[i];
        i_mem_model.mem[16'h0101] = r[1];
        i_mem_model.mem[16'h0201] = r[4];
        i_mem_model.mem[16'h0102] = 8'h80;
        i_mem_model.mem[16'h1234] = r[2];
        i_mem_model.mem[16'h0203] = r[3];
        wq.push_back({16'h0040, r[0]});
        wq.push_back({16'h0041, r[0]});
        wq.push_back({16'h0100, r[0]});
        wq.push_back({16'h0042, r[1]});
        // the stack-to-index copy and the immediate move both leave every flag at its reset value
        ns(16'h0004, 8'h00, 16'h0100, 16'h00ff, 8'h68);
        ns(16'h000e, 8'h00, 16'h0103, 16'h00ff, nz(8'h68, r[1]));
        ns(16'h0011, r[2], 16'h0103, 16'h00ff, nz(8'h68, r[2]));
        ns(16'h0014, r[3], 16'h0103, 16'h00ff, nz(8'h68, r[3]));
        ns(16'h0018, r[4], 16'h0103, 16'h00ff, nz(8'h68, r[4]));
        ns(16'h001d, r[4], 16'h0103, 16'h00ff, 8'h6a);
        ns(16'h001e, 8'h6a, 16'h0103, 16'h00ff, 8'h6a);
        ns(16'h0020, 8'h03, 16'h0103, 16'h0102, 8'h6a);
        ns(16'h0021, 8'h03, 16'h0103, 16'h0102, 8'h62);
        repeat (16) @(negedge clock_i);
        rst_n_i = 1'b1;
        for (k = 0; k < 300 && waiting_o !== 1'b1; k++) @(negedge clock_i);
        repeat (4) @(negedge clock_i);
        cmp_bit(waiting_o === 1'b1 && mem_req_o.rd === 1'b0, "core not halted");
        irq_i = 1'b1;
        @(negedge clock_i);
        irq_i = 1'b0;
        repeat (30) @(negedge clock_i);
        cmp_bit(wq.size() == 0 && sq.size() == 0, "expected results never seen");
        give_verdict();
    end
endmodule
